// ==== logic/gigabit_phy_autoneg_control.sv ====
// Auto-negotiation control with management registers for a 10/100/1000 transceiver
`default_nettype none
module gigabit_phy_autoneg_control #(
  parameter int unsigned BIT_CYC = autoneg_pkg::FLP_BIT_CYC,
  parameter int unsigned BURST_GAP_CYC = autoneg_pkg::BURST_GAP_CYC,
  parameter int unsigned BREAK_CYC = autoneg_pkg::BREAK_LINK_CYC
)(
  input wire logic mclk,
  input wire logic rst,
  input wire autoneg_pkg::mgmt_req_s mgmtReq,
  output logic [15:0] mgmtRdData,
  input wire logic flpRxPulse,
  output logic flpTxPulse,
  input wire logic link10Good,
  input wire logic link100Good,
  input wire logic link1000Good,
  input wire logic nodeMultiport,
  input wire logic anStrapDisable,
  output logic linkUp,
  output logic dataHalt,
  output autoneg_pkg::an_result_s result
);
  localparam logic [27:0] GAP_LOAD = 28'(BURST_GAP_CYC - 1);
  localparam logic [27:0] BREAK_LOAD = 28'(BREAK_CYC - 1);

  autoneg_pkg::an_state_e state_reg, state_next;
  autoneg_pkg::an_result_s result_reg, resNext;
  logic [15:0] ctrl_reg, adv_reg, npt_reg, lpa_reg, lpnp_reg, rdData_reg;
  logic [27:0] tmr_reg;
  logic [1:0] ackCnt_reg;
  logic ackSeen_reg, partnerAble_reg, pageRcvd_reg, pdFault_reg, viaPd_reg;
  logic complete_reg, linkUp_reg, dataHalt_reg, strapOff_reg, strapDone_reg;
  logic txDone, rxValid;
  logic [15:0] rxPage;

  // ==========================================================================
  // Management decode
  wire [4:0] addr = mgmtReq.addr;
  wire wrCtrl = mgmtReq.write && addr == autoneg_pkg::REG_CTRL;
  wire wrAdv = mgmtReq.write && addr == autoneg_pkg::REG_ADV;
  wire wrNpt = mgmtReq.write && addr == autoneg_pkg::REG_NPT;
  wire rdExp = mgmtReq.read && addr == autoneg_pkg::REG_EXP;
  wire restartReq = wrCtrl && mgmtReq.data[autoneg_pkg::CTRL_RESTART];
  // Strap latched after reset release overrides the software enable
  wire anEnable = ctrl_reg[autoneg_pkg::CTRL_AN_EN] && strapDone_reg && !strapOff_reg;

  // ==========================================================================
  // Page transmission
  wire sending = state_reg == autoneg_pkg::ST_DETECT || state_reg == autoneg_pkg::ST_ACK
    || state_reg == autoneg_pkg::ST_NPAGE;
  wire tmrZero = tmr_reg == 28'h0;
  wire txStart = sending && tmrZero;
  wire [15:0] basePage = {adv_reg[15], state_reg == autoneg_pkg::ST_ACK, adv_reg[13:0]};
  wire [15:0] nextPage = {npt_reg[15], 1'b1, npt_reg[13:0]};
  wire [15:0] txPage = state_reg == autoneg_pkg::ST_NPAGE ? nextPage : basePage;

  flp_burst_tx #(
    .BIT_CYC(BIT_CYC)
  ) txBurst (
    .mclk(mclk),
    .rst(rst),
    .start(txStart),
    .page(txPage),
    .pulse(flpTxPulse),
    .done(txDone)
  );

  flp_burst_rx #(
    .BIT_CYC(BIT_CYC)
  ) rxBurst (
    .mclk(mclk),
    .rst(rst),
    .pulseIn(flpRxPulse),
    .pageValid(rxValid),
    .page(rxPage)
  );

  // ==========================================================================
  // Event terms
  wire rxAcked = rxValid && rxPage[autoneg_pkg::PAGE_ACK];
  wire baseRx = rxValid && state_reg == autoneg_pkg::ST_DETECT;
  wire ackDone = state_reg == autoneg_pkg::ST_ACK && ackSeen_reg && ackCnt_reg == autoneg_pkg::ACK_BURSTS;
  wire wantNp = adv_reg[autoneg_pkg::PAGE_NP] && lpa_reg[autoneg_pkg::PAGE_NP];
  wire npRx = rxAcked && state_reg == autoneg_pkg::ST_NPAGE;
  wire npLast = !npt_reg[autoneg_pkg::PAGE_NP] && !rxPage[autoneg_pkg::PAGE_NP];
  // Parallel detection is tried at burst times while no page has arrived
  wire pdTry = state_reg == autoneg_pkg::ST_DETECT && tmr_reg == 28'h1 && !rxValid
    && (link10Good || link100Good);
  wire pd100Adv = adv_reg[autoneg_pkg::ADV_100F] || adv_reg[autoneg_pkg::ADV_100H];
  wire pd10Adv = adv_reg[autoneg_pkg::ADV_10F] || adv_reg[autoneg_pkg::ADV_10H];
  wire pdOk = (link10Good ^ link100Good) && (link100Good ? pd100Adv : pd10Adv);
  wire pdGood = pdTry && pdOk;
  // Both receivers up, an unadvertised technology or a lost link is a fault
  wire pdLost = state_reg == autoneg_pkg::ST_GOOD && viaPd_reg
    && !(result_reg.speed == autoneg_pkg::SPD_100 ? link100Good && !link10Good
                                                  : link10Good && !link100Good);
  wire pdFaultSet = (pdTry && !pdOk) || pdLost;
  wire linkSel = result_reg.speed == autoneg_pkg::SPD_1000 ? link1000Good
    : result_reg.speed == autoneg_pkg::SPD_100 ? link100Good : link10Good;
  wire anLost = state_reg == autoneg_pkg::ST_GOOD && !viaPd_reg && linkUp_reg && !linkSel;
  wire enterGood = state_next == autoneg_pkg::ST_GOOD && state_reg != autoneg_pkg::ST_GOOD;

  // ==========================================================================
  // Next state; disable dominates, a restart write always goes through break
  always_comb
  begin
    state_next = state_reg;
    if (!anEnable)
      state_next = autoneg_pkg::ST_IDLE;
    else if (restartReq)
      state_next = autoneg_pkg::ST_BREAK;
    else
      unique case (state_reg)
        autoneg_pkg::ST_IDLE:
          state_next = autoneg_pkg::ST_BREAK;
        autoneg_pkg::ST_BREAK:
          if (tmrZero)
            state_next = autoneg_pkg::ST_DETECT;
        autoneg_pkg::ST_DETECT:
          if (baseRx)
            state_next = autoneg_pkg::ST_ACK;
          else if (pdGood)
            state_next = autoneg_pkg::ST_GOOD;
          else if (pdFaultSet)
            state_next = autoneg_pkg::ST_BREAK;
        autoneg_pkg::ST_ACK:
          if (ackDone)
            state_next = wantNp ? autoneg_pkg::ST_NPAGE : autoneg_pkg::ST_GOOD;
        autoneg_pkg::ST_NPAGE:
          if (npRx && npLast)
            state_next = autoneg_pkg::ST_GOOD;
        autoneg_pkg::ST_GOOD:
          if (pdLost || anLost)
            state_next = autoneg_pkg::ST_BREAK;
        default:
          state_next = autoneg_pkg::ST_IDLE;
      endcase
  end

  // ==========================================================================
  // Priority resolution over common abilities, best first
  wire c1000F = adv_reg[autoneg_pkg::PAGE_NP] && npt_reg[autoneg_pkg::NP_1000F]
    && lpnp_reg[autoneg_pkg::NP_1000F];
  wire c1000H = adv_reg[autoneg_pkg::PAGE_NP] && npt_reg[autoneg_pkg::NP_1000H]
    && lpnp_reg[autoneg_pkg::NP_1000H];
  wire [3:0] common = adv_reg[8:5] & lpa_reg[8:5];
  wire locMp = nodeMultiport;
  wire parMp = lpnp_reg[autoneg_pkg::NP_MULTIPORT];
  wire seedWin = npt_reg[7:0] > lpnp_reg[7:0];

  always_comb
  begin
    resNext = '0;
    if (c1000F || c1000H)
    begin
      resNext.speed = autoneg_pkg::SPD_1000;
      resNext.fullDuplex = c1000F;
      resNext.master = (locMp && !parMp) || (locMp == parMp && seedWin);
    end
    else if (common[3] || common[2])
    begin
      resNext.speed = autoneg_pkg::SPD_100;
      resNext.fullDuplex = common[3];
    end
    else
    begin
      resNext.speed = autoneg_pkg::SPD_10;
      resNext.fullDuplex = common[1];
    end
    // The MAC resolves pause from these; no pause decision is made here
    if (resNext.fullDuplex)
      resNext.pause = {adv_reg[11:10], lpa_reg[11:10]};
  end

  // ==========================================================================
  // State, timer and strap capture
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      state_reg <= autoneg_pkg::ST_IDLE;
      tmr_reg <= 28'h0;
      strapOff_reg <= 1'b0;
      strapDone_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (!strapDone_reg)
      begin
        strapOff_reg <= anStrapDisable;
        strapDone_reg <= 1'b1;
      end
      if (state_next != state_reg)
        tmr_reg <= state_next == autoneg_pkg::ST_BREAK ? BREAK_LOAD : 28'h0;
      else if (!tmrZero)
        tmr_reg <= tmr_reg - 28'h1;
      else if (sending)
        tmr_reg <= GAP_LOAD;
    end

  // ==========================================================================
  // Software-written registers; restart bit is never stored, so it reads 0
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      ctrl_reg <= autoneg_pkg::CTRL_RST;
      adv_reg <= autoneg_pkg::ADV_RST;
      npt_reg <= autoneg_pkg::NPT_RST;
    end
    else
    begin
      if (wrCtrl)
        ctrl_reg <= mgmtReq.data & ~(16'h0001 << autoneg_pkg::CTRL_RESTART);
      if (wrAdv)
        adv_reg <= mgmtReq.data;
      if (wrNpt)
        npt_reg <= mgmtReq.data;
    end

  // ==========================================================================
  // Negotiation-owned report state; a set in the read cycle beats the clear
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      lpa_reg <= 16'h0000;
      lpnp_reg <= 16'h0000;
      partnerAble_reg <= 1'b0;
      pageRcvd_reg <= 1'b0;
      pdFault_reg <= 1'b0;
      viaPd_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
      ackCnt_reg <= 2'h0;
    end
    else
    begin
      pageRcvd_reg <= (baseRx || npRx) || (pageRcvd_reg && !rdExp);
      pdFault_reg <= pdFaultSet || (pdFault_reg && !rdExp);
      if (state_reg == autoneg_pkg::ST_BREAK)
      begin
        lpnp_reg <= 16'h0000;
        viaPd_reg <= 1'b0;
        ackSeen_reg <= 1'b0;
        ackCnt_reg <= 2'h0;
      end
      if (rxValid && (state_reg == autoneg_pkg::ST_DETECT || state_reg == autoneg_pkg::ST_ACK))
      begin
        lpa_reg <= rxPage;
        partnerAble_reg <= 1'b1;
      end
      else if (pdGood)
      begin
        // Reflect the partner's technology with a valid selector
        lpa_reg <= {8'h00, link100Good, 1'b0, link10Good, autoneg_pkg::SELECTOR_8023};
        partnerAble_reg <= 1'b0;
        viaPd_reg <= 1'b1;
      end
      if (npRx)
        lpnp_reg <= rxPage;
      if (state_reg == autoneg_pkg::ST_ACK && rxAcked)
        ackSeen_reg <= 1'b1;
      if (state_reg == autoneg_pkg::ST_ACK && ackSeen_reg && txDone && !ackDone)
        ackCnt_reg <= ackCnt_reg + 2'h1;
    end

  // ==========================================================================
  // Result, status and read data; reads return one cycle after the strobe
  wire [15:0] statWord = (16'(complete_reg) << autoneg_pkg::STAT_AN_DONE)
    | (16'h0001 << autoneg_pkg::STAT_AN_ABLE) | (16'(linkUp_reg) << autoneg_pkg::STAT_LINK);
  wire [15:0] expWord = (16'(partnerAble_reg) << autoneg_pkg::EXP_LP_ABLE)
    | (16'(pageRcvd_reg) << autoneg_pkg::EXP_PAGE_RX) | (16'(pdFault_reg) << autoneg_pkg::EXP_PD_FAULT);
  wire [15:0] rdMux = addr == autoneg_pkg::REG_CTRL ? ctrl_reg
    : addr == autoneg_pkg::REG_STAT ? statWord
    : addr == autoneg_pkg::REG_ADV ? adv_reg
    : addr == autoneg_pkg::REG_LPA ? lpa_reg
    : addr == autoneg_pkg::REG_EXP ? expWord
    : addr == autoneg_pkg::REG_NPT ? npt_reg : 16'h0000;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      rdData_reg <= 16'h0000;
      result_reg <= '0;
      complete_reg <= 1'b0;
      linkUp_reg <= 1'b0;
      dataHalt_reg <= 1'b0;
    end
    else
    begin
      if (mgmtReq.read)
        rdData_reg <= rdMux;
      if (enterGood)
        result_reg <= pdGood ? '{speed: link100Good ? autoneg_pkg::SPD_100 : autoneg_pkg::SPD_10,
                                 fullDuplex: 1'b0, master: 1'b0, pause: 4'h0} : resNext;
      complete_reg <= state_next == autoneg_pkg::ST_GOOD;
      linkUp_reg <= state_reg == autoneg_pkg::ST_GOOD && state_next == autoneg_pkg::ST_GOOD && linkSel;
      dataHalt_reg <= state_next == autoneg_pkg::ST_BREAK;
    end

  assign mgmtRdData = rdData_reg;
  assign result = result_reg;
  assign linkUp = linkUp_reg;
  assign dataHalt = dataHalt_reg;
endmodule
`default_nettype wire

// ==== logic/autoneg_pkg.sv ====
// Shared constants, types and timing for the auto-negotiation control block
`default_nettype none
package autoneg_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned FLP_BIT_NS = 125000;       // Clock-to-clock spacing inside a burst
  localparam int unsigned BURST_GAP_NS = 16000000;   // Burst-to-burst spacing
  localparam int unsigned BREAK_LINK_NS = 1200000000; // Silence after a restart
  localparam int unsigned FLP_BIT_CYC = (FLP_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BURST_GAP_CYC = (BURST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BREAK_LINK_CYC = (BREAK_LINK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 28;
  localparam logic [1:0] ACK_BURSTS = 2'h3;          // Acknowledged bursts before leaving ACK

  // ==========================================================================
  // Register offsets (16-bit management registers)
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LPA = 5'h05;
  localparam logic [4:0] REG_EXP = 5'h06;
  localparam logic [4:0] REG_NPT = 5'h07;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_AN_EN = 12;
  localparam int unsigned CTRL_RESTART = 9;
  localparam int unsigned STAT_AN_DONE = 5;
  localparam int unsigned STAT_AN_ABLE = 3;
  localparam int unsigned STAT_LINK = 2;
  localparam int unsigned ADV_ASYM = 11;
  localparam int unsigned ADV_PAUSE = 10;
  localparam int unsigned ADV_100F = 8;
  localparam int unsigned ADV_100H = 7;
  localparam int unsigned ADV_10F = 6;
  localparam int unsigned ADV_10H = 5;
  localparam int unsigned PAGE_NP = 15;
  localparam int unsigned PAGE_ACK = 14;
  localparam int unsigned NP_MULTIPORT = 10;
  localparam int unsigned NP_1000F = 9;
  localparam int unsigned NP_1000H = 8;
  localparam int unsigned EXP_LP_ABLE = 0;
  localparam int unsigned EXP_PAGE_RX = 1;
  localparam int unsigned EXP_PD_FAULT = 4;
  localparam logic [4:0] SELECTOR_8023 = 5'h01;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h1000;
  localparam logic [15:0] ADV_RST = 16'h0de1;
  localparam logic [15:0] NPT_RST = 16'h2001;

  // ==========================================================================
  // Speed codes
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // Gray-coded along idle, break, detect, acknowledge, next page, good
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BREAK = 3'h1,
    ST_DETECT = 3'h3,
    ST_ACK = 3'h2,
    ST_NPAGE = 3'h6,
    ST_GOOD = 3'h7
  } an_state_e;

  typedef struct packed {
    logic write;
    logic read;
    logic [4:0] addr;
    logic [15:0] data;
  } mgmt_req_s;

  typedef struct packed {
    logic [1:0] speed;
    logic fullDuplex;
    logic master;
    logic [3:0] pause; // {local asym, local pause, partner asym, partner pause}
  } an_result_s;
endpackage
`default_nettype wire

// ==== logic/flp_burst_tx.sv ====
// Serialises one 16-bit page into a Fast Link Pulse burst
`default_nettype none
module flp_burst_tx #(
  parameter int unsigned BIT_CYC = autoneg_pkg::FLP_BIT_CYC
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] page,
  output logic pulse,
  output logic done
);
  localparam logic [27:0] LAST = 28'(BIT_CYC - 1);
  localparam logic [27:0] HALF = 28'(BIT_CYC / 2);
  logic [27:0] tmr_reg;
  logic [4:0] slot_reg;
  logic [15:0] page_reg;
  logic busy_reg;
  logic pulse_reg;
  logic done_reg;

  // ==========================================================================
  // Slot timing: clock pulse at slot start, data pulse mid-slot for a one
  wire clkPulse = busy_reg && tmr_reg == 28'h0;
  wire dataPulse = busy_reg && tmr_reg == HALF && !slot_reg[4] && page_reg[slot_reg[3:0]];
  wire slotEnd = busy_reg && tmr_reg == LAST;

  // Seventeen clock pulses frame sixteen data slots; start is ignored while busy
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      tmr_reg <= 28'h0;
      slot_reg <= 5'h00;
      page_reg <= 16'h0000;
      busy_reg <= 1'b0;
      pulse_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      pulse_reg <= clkPulse || dataPulse;
      done_reg <= slotEnd && slot_reg == 5'h10;
      if (start && !busy_reg)
      begin
        busy_reg <= 1'b1;
        page_reg <= page;
        tmr_reg <= 28'h0;
        slot_reg <= 5'h00;
      end
      else if (slotEnd)
      begin
        tmr_reg <= 28'h0;
        slot_reg <= slot_reg + 5'h01;
        busy_reg <= slot_reg != 5'h10;
      end
      else if (busy_reg)
        tmr_reg <= tmr_reg + 28'h1;
    end

  assign pulse = pulse_reg;
  assign done = done_reg;
endmodule
`default_nettype wire

// ==== logic/flp_burst_rx.sv ====
// Recovers a 16-bit page from received Fast Link Pulse bursts
`default_nettype none
module flp_burst_rx #(
  parameter int unsigned BIT_CYC = autoneg_pkg::FLP_BIT_CYC
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic pulseIn,
  output logic pageValid,
  output logic [15:0] page
);
  localparam logic [27:0] Q1 = 28'(BIT_CYC / 4);
  localparam logic [27:0] Q3 = 28'((3 * BIT_CYC) / 4);
  localparam logic [27:0] LOST = 28'((5 * BIT_CYC) / 4);
  logic [27:0] tmr_reg;
  logic [4:0] cnt_reg;
  logic [15:0] shf_reg;
  logic [15:0] page_reg;
  logic dat_reg;
  logic act_reg;
  logic valid_reg;

  // ==========================================================================
  // Window classification; early pulses are treated as noise
  wire inData = act_reg && tmr_reg >= Q1 && tmr_reg < Q3;
  wire isClock = pulseIn && (!act_reg || tmr_reg >= Q3);
  wire lastBit = cnt_reg == 5'h0f;

  // A clock pulse closes the previous slot; a stalled burst is dropped
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      tmr_reg <= 28'h0;
      cnt_reg <= 5'h00;
      shf_reg <= 16'h0000;
      page_reg <= 16'h0000;
      dat_reg <= 1'b0;
      act_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      valid_reg <= 1'b0;
      if (isClock)
      begin
        tmr_reg <= 28'h0;
        dat_reg <= 1'b0;
        if (act_reg)
        begin
          shf_reg <= {dat_reg, shf_reg[15:1]};
          cnt_reg <= lastBit ? 5'h00 : cnt_reg + 5'h01;
          act_reg <= !lastBit;
          valid_reg <= lastBit;
          if (lastBit)
            page_reg <= {dat_reg, shf_reg[15:1]};
        end
        else
          act_reg <= 1'b1;
      end
      else if (pulseIn && inData)
        dat_reg <= 1'b1;
      else if (act_reg && tmr_reg > LOST)
      begin
        act_reg <= 1'b0;
        cnt_reg <= 5'h00;
      end
      else if (act_reg)
        tmr_reg <= tmr_reg + 28'h1;
    end

  assign pageValid = valid_reg;
  assign page = page_reg;
endmodule
`default_nettype wire

// ==== tb/autoneg_assertions.sv ====
// Port-level checks for the auto-negotiation control block
`default_nettype none
module autoneg_assertions #(
  parameter int unsigned BIT_CYC = 40,
  parameter int unsigned BURST_GAP_CYC = 2000,
  parameter int unsigned BREAK_CYC = 100
)(
  input wire logic mclk,
  input wire logic rst,
  input wire autoneg_pkg::mgmt_req_s mgmtReq,
  input wire logic [15:0] mgmtRdData,
  input wire logic flpRxPulse,
  input wire logic flpTxPulse,
  input wire logic link10Good,
  input wire logic link100Good,
  input wire logic link1000Good,
  input wire logic nodeMultiport,
  input wire logic anStrapDisable,
  input wire logic linkUp,
  input wire logic dataHalt,
  input wire autoneg_pkg::an_result_s result
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Decodes of the management request
  wire ctrlWr = mgmtReq.write && mgmtReq.addr == autoneg_pkg::REG_CTRL;
  wire statRd = mgmtReq.read && mgmtReq.addr == autoneg_pkg::REG_STAT;
  wire unmapped = !(mgmtReq.addr inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07});
  wire offWr = ctrlWr && !mgmtReq.data[12];
  // Counts halt cycles; the break length is too long for a repetition
  logic [27:0] haltCnt_reg;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      haltCnt_reg <= 28'h0;
    else
      haltCnt_reg <= dataHalt ? haltCnt_reg + 28'h1 : 28'h0;
  // ==========================================================================
  // Properties
  property p_halt_quiet; dataHalt |-> !flpTxPulse; endproperty
  property p_restart; ctrlWr && mgmtReq.data[9] && mgmtReq.data[12] && !anStrapDisable
    |=> dataHalt; endproperty
  property p_break_len; $fell(dataHalt) && !$past(offWr, 2) |-> haltCnt_reg >= BREAK_CYC - 1 &&
    haltCnt_reg <= BREAK_CYC + 1; endproperty
  property p_resume; $fell(dataHalt) && !$past(offWr, 2) |-> ##[1:3] flpTxPulse; endproperty
  property p_disable; offWr |-> ##[1:2] (!dataHalt && !linkUp);
  endproperty
  property p_good_quiet; linkUp |-> !flpTxPulse && !dataHalt; endproperty
  property p_half_nopause; !result.fullDuplex |-> result.pause == 4'h0; endproperty
  property p_master; result.master |-> result.speed == autoneg_pkg::SPD_1000; endproperty
  property p_unmapped; mgmtReq.read && unmapped |=> mgmtRdData == 16'h0000; endproperty
  property p_stat_able; statRd |=> mgmtRdData[3]; endproperty
  a_halt_quiet: assert property (p_halt_quiet)
    else $error("pulse during break");
  a_restart: assert property (p_restart)
    else $error("restart did not halt");
  a_break_len: assert property (p_break_len)
    else $error("break length wrong");
  a_resume: assert property (p_resume)
    else $error("no burst after break");
  a_disable: assert property (p_disable)
    else $error("disable not idle");
  a_good_quiet: assert property (p_good_quiet)
    else $error("pulses with link up");
  a_half_nopause: assert property (p_half_nopause)
    else $error("pause in half duplex");
  a_master: assert property (p_master)
    else $error("master below 1000");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_stat_able: assert property (p_stat_able)
    else $error("ability bit clear");
  c_link: cover property ($rose(linkUp));
  c_break: cover property ($rose(dataHalt));
  c_pd10: cover property (linkUp && result.speed == autoneg_pkg::SPD_10);
endmodule
bind gigabit_phy_autoneg_control autoneg_assertions #(.BIT_CYC(BIT_CYC),
  .BURST_GAP_CYC(BURST_GAP_CYC), .BREAK_CYC(BREAK_CYC)) i_chk (.mclk(mclk), .rst(rst),
  .mgmtReq(mgmtReq), .mgmtRdData(mgmtRdData), .flpRxPulse(flpRxPulse),
  .flpTxPulse(flpTxPulse), .link10Good(link10Good), .link100Good(link100Good),
  .link1000Good(link1000Good), .nodeMultiport(nodeMultiport),
  .anStrapDisable(anStrapDisable), .linkUp(linkUp), .dataHalt(dataHalt), .result(result));
`default_nettype wire

// ==== tb/link_partner_model.sv ====
// Link partner that repeats one page as pulse bursts
`default_nettype none
module link_partner_model #(
  parameter int unsigned BIT_CYC = 40,
  parameter int unsigned GAP_CYC = 2000
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [15:0] page,
  output logic pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock pulse opens a slot, data pulse mid-slot for a one
  task automatic slot(input logic dataBit);
    pulse <= 1'b1;
    @(posedge mclk) pulse <= 1'b0;
    repeat (BIT_CYC / 2 - 1) @(posedge mclk);
    pulse <= dataBit;
    @(posedge mclk) pulse <= 1'b0;
    repeat (BIT_CYC / 2 - 1) @(posedge mclk);
  endtask
  // Line idles low; enable is only looked at between bursts
  initial
  begin
    pulse = 1'b0;
    forever
    begin
      @(posedge mclk);
      if (!rst && enable)
      begin
        for (int i = 0; i < 16; i++)
          slot(page[i]);
        slot(1'b0);
        repeat (GAP_CYC - 17 * BIT_CYC) @(posedge mclk);
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_gigabit_phy_autoneg_control.sv ====
// Self-checking bench for the auto-negotiation control block
`default_nettype none
module test_gigabit_phy_autoneg_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  autoneg_pkg::mgmt_req_s mgmtReq = '0;
  logic [15:0] mgmtRdData;
  logic flpRxPulse, flpTxPulse, linkUp, dataHalt;
  logic link10Good = 1'b0;
  logic link100Good = 1'b0;
  logic [2:0] ties = 3'h0;
  logic partnerOn = 1'b0;
  logic [15:0] partnerPage = 16'h0000;
  logic [1:0] advPause, lpPause;
  autoneg_pkg::an_result_s result;
  int errCount = 0;
  int comparisons = 0;
  int seed = 32'h32ec63ab;
  logic [15:0] regModel [8];
  logic [15:0] rdVal;
  always #4 mclk = ~mclk;
  gigabit_phy_autoneg_control #(.BIT_CYC(40), .BURST_GAP_CYC(2000), .BREAK_CYC(100)) i_dut (
    .mclk(mclk), .rst(rst), .mgmtReq(mgmtReq), .mgmtRdData(mgmtRdData),
    .flpRxPulse(flpRxPulse), .flpTxPulse(flpTxPulse), .link10Good(link10Good),
    .link100Good(link100Good), .link1000Good(ties[0]), .nodeMultiport(ties[1]),
    .anStrapDisable(ties[2]), .linkUp(linkUp), .dataHalt(dataHalt), .result(result));
  link_partner_model #(.BIT_CYC(40), .GAP_CYC(2000)) i_partner (.mclk(mclk), .rst(rst),
    .enable(partnerOn), .page(partnerPage), .pulse(flpRxPulse));
  // ==========================================================================
  // Compare, register access and completion polling
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    #1 mgmtReq = '{wr, !wr, a, d};
    @(posedge mclk);
    #1 mgmtReq = '0;
    rdVal = mgmtRdData;
  endtask
  // Bounded poll of the complete flag, so a stuck negotiation cannot hang
  task automatic waitDone();
    rdVal = 16'h0000;
    for (int n = 0; n < 300 && rdVal[5] !== 1'b1; n++)
    begin
      repeat (100) @(posedge mclk);
      access(1'b0, autoneg_pkg::REG_STAT, 16'h0);
    end
    check(rdVal & 16'h0028, 16'h0028);
  endtask
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    advPause = 2'($random(seed));
    lpPause = 2'($random(seed));
    regModel[4] = {4'h0, advPause, 10'h1e1};
    regModel[7] = 16'($random(seed));
    access(1'b0, autoneg_pkg::REG_ADV, 16'h0);
    check(rdVal, autoneg_pkg::ADV_RST);
    access(1'b0, autoneg_pkg::REG_NPT, 16'h0);
    check(rdVal, autoneg_pkg::NPT_RST);
    foreach (regModel[a])
      if (a == 4 || a == 7)
      begin
        access(1'b1, 5'(a), regModel[a]);
        access(1'b0, 5'(a), 16'h0);
        check(rdVal, regModel[a]);
      end
    access(1'b1, autoneg_pkg::REG_LPA, 16'hffff);
    access(1'b0, autoneg_pkg::REG_LPA, 16'h0);
    check(rdVal, 16'h0000);
    access(1'b0, 5'h1b, 16'h0);
    check(rdVal, 16'h0000);
    $display("test done: registers");
    partnerPage = {4'h4, lpPause, 10'h101};
    partnerOn = 1'b1;
    waitDone();
    partnerOn = 1'b0;
    check({8'h0, result}, {8'h0, autoneg_pkg::SPD_100, 2'h2, advPause, lpPause});
    access(1'b0, autoneg_pkg::REG_LPA, 16'h0);
    check(rdVal & 16'h0c00, {4'h0, lpPause, 10'h0});
    access(1'b0, autoneg_pkg::REG_EXP, 16'h0);
    check(rdVal & 16'h0001, 16'h0001);
    link100Good = 1'b1;
    repeat (2000) @(posedge mclk);
    check({15'h0, linkUp}, 16'h0001);
    $display("test done: page exchange");
    #1 link100Good = 1'b0;
    access(1'b1, autoneg_pkg::REG_CTRL, 16'h0000);
    link10Good = 1'b1;
    access(1'b1, autoneg_pkg::REG_CTRL, 16'h1000);
    @(posedge mclk) #1 check({15'h0, dataHalt}, 16'h0001);
    waitDone();
    access(1'b0, autoneg_pkg::REG_LPA, 16'h0);
    check(rdVal, 16'h0021);
    access(1'b0, autoneg_pkg::REG_EXP, 16'h0);
    check(rdVal & 16'h0001, 16'h0000);
    check({7'h0, linkUp, result}, {7'h0, 1'b1, autoneg_pkg::SPD_10, 6'h0});
    $display("test done: parallel detect");
    link100Good = 1'b1;
    repeat (900) @(posedge mclk);
    access(1'b0, autoneg_pkg::REG_EXP, 16'h0);
    check(rdVal & 16'h0010, 16'h0010);
    access(1'b0, autoneg_pkg::REG_EXP, 16'h0);
    check(rdVal & 16'h0010, 16'h0000);
    access(1'b1, autoneg_pkg::REG_CTRL, 16'h1200);
    check({15'h0, dataHalt}, 16'h0001);
    access(1'b0, autoneg_pkg::REG_CTRL, 16'h0);
    check(rdVal, autoneg_pkg::CTRL_RST);
    $display("test done: fault and restart");
    closeOut();
  end
  // Watchdog sized well above the two negotiations
  initial
  begin
    #(60000 * 8);
    errCount++;
    closeOut();
  end
endmodule
`default_nettype wire
